// ===== rtl/otf_pkg.sv
// otf_pkg: constants, field layout and state type for the over-temperature
// fault response block.
// assumes: plain SystemVerilog, no imports; all users write otf_pkg::name.
package otf_pkg;

  // ----------------------------------------------------------------------
  // command codes of the two registers
  // ----------------------------------------------------------------------
  localparam logic [7:0] OTF_CMD_THRESHOLD = 8'h4F;
  localparam logic [7:0] OTF_CMD_ACTION = 8'h50;

  // ----------------------------------------------------------------------
  // field positions in the action byte
  // ----------------------------------------------------------------------
  localparam int OTF_RESP_MSB = 7;
  localparam int OTF_RESP_LSB = 6;
  localparam int OTF_RETRY_MSB = 5;
  localparam int OTF_RETRY_LSB = 3;
  localparam int OTF_DELAY_MSB = 2;
  localparam int OTF_DELAY_LSB = 0;

  // response codes
  localparam logic [1:0] OTF_RESP_IGNORE = 2'h0;
  localparam logic [1:0] OTF_RESP_CONTINUE = 2'h1;
  localparam logic [1:0] OTF_RESP_DISABLE = 2'h2;
  localparam logic [1:0] OTF_RESP_LATCH = 2'h3;

  // retry codes with a special meaning; 1..6 are plain attempt counts
  localparam logic [2:0] OTF_RETRY_NONE = 3'h0;
  localparam logic [2:0] OTF_RETRY_FOREVER = 3'h7;

  // ----------------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------------
  // threshold reset: linear format, exponent 0, mantissa 125 (125 degC)
  localparam logic [15:0] OTF_THRESHOLD_RST = 16'h007D;
  // action reset: disable output, no retry, delay code 0
  localparam logic [7:0] OTF_ACTION_RST = 8'h80;
  localparam int OTF_TIMER_W = 24;
  localparam int OTF_FIX_W = 48;

  // ----------------------------------------------------------------------
  // response state machine
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OTF_ST_RUN = 4'h1,
    OTF_ST_DELAY = 4'h2,
    OTF_ST_RETRY = 4'h4,
    OTF_ST_LATCH = 4'h8
  } otf_state_t;

  // linear format (5-bit signed exponent, 11-bit signed mantissa) to a
  // signed fixed-point value with 16 fraction bits; exponent + 16 is just
  // the exponent with its sign bit inverted, so no adder is needed
  function automatic logic signed [OTF_FIX_W-1:0] otf_lin_to_fix(
    input logic [15:0] v
  );
    logic signed [OTF_FIX_W-1:0] mant;
    logic [4:0] shamt;
    mant = {{(OTF_FIX_W-11){v[10]}}, v[10:0]};
    shamt = {~v[15], v[14:11]};
    otf_lin_to_fix = mant <<< shamt;
  endfunction

endpackage

// ===== rtl/otf_delay_timer.sv
// otf_delay_timer: one-shot timer of (unit length << code) clock cycles.
// assumes: unitCycles is the delay time unit in clk cycles, set elsewhere
// by the time-unit configuration; it is sampled only at start.
`timescale 1ns/1ps
module otf_delay_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [15:0] unitCycles,
  input wire logic [2:0] code,
  output logic busy,
  output logic expired
);

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  logic [otf_pkg::OTF_TIMER_W-1:0] cnt_q;
  logic [otf_pkg::OTF_TIMER_W-1:0] load;
  logic busy_q;

  // code n gives 2^n units; a zero unit still yields one cycle
  always_comb begin
    load = {8'h00, unitCycles} << code;
    if (load == '0) begin
      load = {{(otf_pkg::OTF_TIMER_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= load;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= {{(otf_pkg::OTF_TIMER_W-1){1'b0}}, 1'b1}) begin
        busy_q <= 1'b0;
      end
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // pulse exactly load cycles after start
  assign expired = busy_q && (cnt_q == {{(otf_pkg::OTF_TIMER_W-1){1'b0}}, 1'b1});
  assign busy = busy_q;

endmodule

// ===== rtl/otf_fault_response.sv
// otf_fault_response: over-temperature limit, fault response byte and the
// shutdown / restart sequencer of a power module's management controller.
// assumes: the management link decodes transfers into regWrEn/regRdEn with
// a command code; temperature arrives already in linear format.
// Summary of operation
// - 16-bit RW temperature threshold at 0x4F
// - response byte at 0x50, read and write
// - code 00 ignores fault, output stays on
// - code 01 runs for delay, then retries
// - code 10 disables at once, then retries
// - code 11 stays off until fault cleared
// - retry 000 means no restart, stay off
// - retry 001 restarts once, then latches off
// - retry 010 restarts twice, then latches off
// - restart spacing equals delay count times unit
// - low three bits give delay unit count as a power of two
// - delay codes map to 1..128 units
// - retry 011..110 give 3..6 attempts
// - retry 111 retries until commanded off
`timescale 1ns/1ps
module otf_fault_response (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] temperature,
  input wire logic [15:0] unitCycles,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData,
  output logic rdAck,
  output logic cmdUnmapped,
  input wire logic clearFaults,
  input wire logic clearStatusBit,
  input wire logic outputOnCmd,
  input wire logic otherFaultOff,
  output logic outputEnable,
  output logic overTempStatus,
  output logic latchedOff
);

  // ----------------------------------------------------------------------
  // registers reached by command code
  // ----------------------------------------------------------------------
  logic [15:0] threshold_q;
  logic [7:0] action_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      threshold_q <= otf_pkg::OTF_THRESHOLD_RST;
      action_q <= otf_pkg::OTF_ACTION_RST;
    end else if (regWrEn) begin
      if (cmdCode == otf_pkg::OTF_CMD_THRESHOLD) begin
        threshold_q <= wrData;
      end
      if (cmdCode == otf_pkg::OTF_CMD_ACTION) begin
        // byte transfer: only the low byte of the word is meaningful
        action_q <= wrData[7:0];
      end
    end
  end

  // field views of the action byte
  logic [1:0] respCode;
  logic [2:0] retryCode;
  logic [2:0] delayCode;

  assign respCode = action_q[otf_pkg::OTF_RESP_MSB:otf_pkg::OTF_RESP_LSB];
  assign retryCode = action_q[otf_pkg::OTF_RETRY_MSB:otf_pkg::OTF_RETRY_LSB];
  assign delayCode = action_q[otf_pkg::OTF_DELAY_MSB:otf_pkg::OTF_DELAY_LSB];

  // ----------------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------------
  logic [15:0] rdData_q;
  logic rdAck_q;
  logic unmapped_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdData_q <= 16'h0000;
      rdAck_q <= 1'b0;
      unmapped_q <= 1'b0;
    end else begin
      rdAck_q <= regRdEn;
      if (regRdEn) begin
        case (cmdCode)
          otf_pkg::OTF_CMD_THRESHOLD: begin
            rdData_q <= threshold_q;
            unmapped_q <= 1'b0;
          end
          otf_pkg::OTF_CMD_ACTION: begin
            rdData_q <= {8'h00, action_q};
            unmapped_q <= 1'b0;
          end
          default: begin
            rdData_q <= 16'h0000;
            unmapped_q <= 1'b1;
          end
        endcase
      end
    end
  end

  assign rdData = rdData_q;
  assign rdAck = rdAck_q;
  assign cmdUnmapped = unmapped_q;

  // ----------------------------------------------------------------------
  // fault detection
  // ----------------------------------------------------------------------
  // both operands go through the same conversion so that differing
  // exponents still compare correctly; registered to keep the wide
  // shifters out of the sequencer's path, at one cycle of latency
  logic overTemp_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      overTemp_q <= 1'b0;
    end else begin
      overTemp_q <= otf_pkg::otf_lin_to_fix(temperature) >=
                    otf_pkg::otf_lin_to_fix(threshold_q);
    end
  end

  // output commanded off then back on clears the fault
  logic onCmd_q;
  logic onRise;
  logic faultClear;

  // resets to the on level so a pin held on through reset is not a rising edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      onCmd_q <= 1'b1;
    end else begin
      onCmd_q <= outputOnCmd;
    end
  end

  assign onRise = outputOnCmd && !onCmd_q;
  assign faultClear = clearFaults || clearStatusBit || onRise;

  // sticky status: a fault seen in the clearing cycle keeps the bit set
  logic status_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= 1'b0;
    end else begin
      status_q <= overTemp_q || (status_q && !faultClear);
    end
  end

  assign overTempStatus = status_q;

  // ----------------------------------------------------------------------
  // delay timer
  // ----------------------------------------------------------------------
  logic timerStart;
  logic timerExpired;

  otf_delay_timer u_timer (
    .clk(clk),
    .rstn(rstn),
    .start(timerStart),
    .unitCycles(unitCycles),
    .code(delayCode),
    .busy(),
    .expired(timerExpired)
  );

  // ----------------------------------------------------------------------
  // response sequencer
  // ----------------------------------------------------------------------
  otf_pkg::otf_state_t state_q;
  otf_pkg::otf_state_t state_d;
  logic [2:0] attempts_q;
  logic [2:0] attempts_d;
  logic outEn_q;
  logic outEn_d;
  logic enterRetry;

  always_comb begin
    state_d = state_q;
    attempts_d = attempts_q;
    outEn_d = outEn_q;
    timerStart = 1'b0;
    enterRetry = 1'b0;
    case (state_q)
      otf_pkg::OTF_ST_RUN: begin
        outEn_d = outputOnCmd;
        if (overTemp_q && outputOnCmd) begin
          case (respCode)
            otf_pkg::OTF_RESP_IGNORE: begin
              state_d = otf_pkg::OTF_ST_RUN;
            end
            otf_pkg::OTF_RESP_CONTINUE: begin
              state_d = otf_pkg::OTF_ST_DELAY;
              timerStart = 1'b1;
            end
            otf_pkg::OTF_RESP_DISABLE: begin
              enterRetry = 1'b1;
            end
            default: begin
              outEn_d = 1'b0;
              state_d = otf_pkg::OTF_ST_LATCH;
            end
          endcase
        end
      end
      otf_pkg::OTF_ST_DELAY: begin
        // output stays on while the delay runs
        outEn_d = outputOnCmd;
        if (!outputOnCmd) begin
          state_d = otf_pkg::OTF_ST_RUN;
        end else if (timerExpired) begin
          if (overTemp_q) begin
            enterRetry = 1'b1;
          end else begin
            state_d = otf_pkg::OTF_ST_RUN;
          end
        end
      end
      otf_pkg::OTF_ST_RETRY: begin
        outEn_d = 1'b0;
        if (!outputOnCmd) begin
          // commanded off ends even the endless retry
          state_d = otf_pkg::OTF_ST_RUN;
        end else if (otherFaultOff) begin
          state_d = otf_pkg::OTF_ST_LATCH;
        end else if (timerExpired) begin
          if (!overTemp_q) begin
            outEn_d = 1'b1;
            state_d = otf_pkg::OTF_ST_RUN;
          end else if (retryCode == otf_pkg::OTF_RETRY_FOREVER) begin
            timerStart = 1'b1;
          end else if (attempts_q <= 3'h1) begin
            state_d = otf_pkg::OTF_ST_LATCH;
          end else begin
            attempts_d = attempts_q - 3'h1;
            timerStart = 1'b1;
          end
        end
      end
      otf_pkg::OTF_ST_LATCH: begin
        outEn_d = 1'b0;
      end
      default: begin
        outEn_d = 1'b0;
        state_d = otf_pkg::OTF_ST_LATCH;
      end
    endcase

    if (enterRetry) begin
      outEn_d = 1'b0;
      if (retryCode == otf_pkg::OTF_RETRY_NONE) begin
        state_d = otf_pkg::OTF_ST_LATCH;
      end else begin
        state_d = otf_pkg::OTF_ST_RETRY;
        attempts_d = retryCode;
        timerStart = 1'b1;
      end
    end

    // a clear returns to normal from any fault state
    if (faultClear && state_q != otf_pkg::OTF_ST_RUN) begin
      state_d = otf_pkg::OTF_ST_RUN;
      timerStart = 1'b0;
      outEn_d = outputOnCmd;
    end

    // another fault's shutdown overrides every output enable set here
    if (otherFaultOff) begin
      outEn_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= otf_pkg::OTF_ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      attempts_q <= 3'h0;
    end else begin
      attempts_q <= attempts_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      outEn_q <= 1'b0;
    end else begin
      outEn_q <= outEn_d;
    end
  end

  assign outputEnable = outEn_q;
  assign latchedOff = (state_q == otf_pkg::OTF_ST_LATCH);

endmodule

// ===== dv/otf_fault_response_assertions.sv
// otf_fault_response_assertions: port-level checks of the fault block.
// assumes: bound to otf_fault_response; register values mirrored from writes.
`timescale 1ns/1ps
module otf_fault_response_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] temperature,
  input wire logic [15:0] unitCycles,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] wrData,
  input wire logic [15:0] rdData,
  input wire logic rdAck,
  input wire logic cmdUnmapped,
  input wire logic clearFaults,
  input wire logic clearStatusBit,
  input wire logic outputOnCmd,
  input wire logic otherFaultOff,
  input wire logic outputEnable,
  input wire logic overTempStatus,
  input wire logic latchedOff
);
  logic [15:0] thrQ;
  logic [7:0] actQ;
  logic hot;
  // only exponent-0 values are judged; others leave the antecedents false
  assign hot = thrQ[15:11] == 5'h00 && temperature[15:11] == 5'h00
    && $signed(temperature[10:0]) >= $signed(thrQ[10:0]);
  always_ff @(posedge clk) begin
    if (!rstn) thrQ <= otf_pkg::OTF_THRESHOLD_RST;
    else if (regWrEn && cmdCode == otf_pkg::OTF_CMD_THRESHOLD) thrQ <= wrData;
  end
  always_ff @(posedge clk) begin
    if (!rstn) actQ <= otf_pkg::OTF_ACTION_RST;
    else if (regWrEn && cmdCode == otf_pkg::OTF_CMD_ACTION) actQ <= wrData[7:0];
  end
  // ------
  // properties
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ack; regRdEn |=> rdAck; endproperty
  a_ack: assert property (p_ack) else $error("read not acknowledged");
  property p_noAck; !regRdEn |=> !rdAck; endproperty
  a_noAck: assert property (p_noAck) else $error("stray acknowledge");
  property p_unmap;
    regRdEn && cmdCode != otf_pkg::OTF_CMD_THRESHOLD && cmdCode != otf_pkg::OTF_CMD_ACTION
      |=> cmdUnmapped && rdData == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read wrong");
  property p_thrRd; regRdEn && cmdCode == otf_pkg::OTF_CMD_THRESHOLD |=> rdData == $past(thrQ);
  endproperty
  a_thrRd: assert property (p_thrRd) else $error("threshold readback wrong");
  property p_actRd;
    regRdEn && cmdCode == otf_pkg::OTF_CMD_ACTION |=> rdData == {8'h00, $past(actQ)};
  endproperty
  a_actRd: assert property (p_actRd) else $error("action readback wrong");
  property p_status; hot ##1 hot |=> overTempStatus; endproperty
  a_status: assert property (p_status) else $error("status not set");
  property p_ignore;
    actQ[7:6] == otf_pkg::OTF_RESP_IGNORE && outputEnable && outputOnCmd && !otherFaultOff
      |=> outputEnable;
  endproperty
  a_ignore: assert property (p_ignore) else $error("output dropped on ignore");
  property p_disable; actQ[7] && hot ##1 hot |=> !outputEnable; endproperty
  a_disable: assert property (p_disable) else $error("output not disabled");
  property p_latchHold;
    latchedOff && !clearFaults && !clearStatusBit && !$rose(outputOnCmd) |=> latchedOff;
  endproperty
  a_latchHold: assert property (p_latchHold) else $error("latch left uncleared");
  property p_latchOff; latchedOff |-> !outputEnable; endproperty
  a_latchOff: assert property (p_latchOff) else $error("output on while latched");
  property p_other; otherFaultOff |=> !outputEnable; endproperty
  a_other: assert property (p_other) else $error("output on after other fault");
  property p_forever;
    actQ[7:3] == {otf_pkg::OTF_RESP_DISABLE, otf_pkg::OTF_RETRY_FOREVER} && outputOnCmd
      && !otherFaultOff && !latchedOff |=> !latchedOff;
  endproperty
  a_forever: assert property (p_forever) else $error("endless retry latched");
  c_latch: cover property ($rose(latchedOff));
  c_restart: cover property ($rose(outputEnable));
  c_unmap: cover property (cmdUnmapped);
endmodule

// ===== dv/otf_host_model.sv
// otf_host_model: management host issuing register transfers.
// assumes: strobes taken on the rising edge, answer one cycle later.
`timescale 1ns/1ps
module otf_host_model (
  input wire logic clk,
  input wire logic rdAck,
  input wire logic [15:0] rdData,
  input wire logic cmdUnmapped,
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] cmdCode,
  output logic [15:0] wrData
);
  initial begin
    regWrEn = 1'h0;
    regRdEn = 1'h0;
    cmdCode = 8'h00;
    wrData = 16'h0000;
  end
  // released lines show the inverse of the last value so stale data never matches
  task wr(input logic [7:0] c, input logic [15:0] v);
    @(negedge clk);
    regWrEn = 1'h1;
    cmdCode = c;
    wrData = v;
    @(negedge clk);
    regWrEn = 1'h0;
    cmdCode = ~c;
    wrData = ~v;
  endtask
  task rd(input logic [7:0] c, output logic [15:0] v, output logic u);
    @(negedge clk);
    regRdEn = 1'h1;
    cmdCode = c;
    @(negedge clk);
    regRdEn = 1'h0;
    cmdCode = ~c;
    v = (rdAck === 1'h1) ? rdData : 16'hXXXX;
    u = cmdUnmapped;
  endtask
endmodule

// ===== dv/otf_fault_response_bench.sv
// otf_fault_response_bench: register, response, retry and timing tests.
// assumes: host model drives the register strobes; unit length is 4 cycles.
`timescale 1ns/1ps
module otf_fault_response_bench;
  localparam logic [15:0] hotTemp = 16'h0064;
  localparam logic [15:0] coolTemp = 16'h0010;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [15:0] temperature = coolTemp;
  logic [15:0] unitCycles = 16'h0004;
  logic clearFaults = 1'h0;
  logic clearStatusBit = 1'h0;
  logic outputOnCmd = 1'h1;
  logic otherFaultOff = 1'h0;
  logic regWrEn, regRdEn, rdAck, cmdUnmapped, outputEnable, overTempStatus, latchedOff, u;
  logic [7:0] cmdCode;
  logic [15:0] wrData, rdData, d;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  always #2.5 clk = ~clk;
  otf_fault_response u_dut (.clk(clk), .rstn(rstn), .temperature(temperature),
    .unitCycles(unitCycles), .regWrEn(regWrEn), .regRdEn(regRdEn), .cmdCode(cmdCode),
    .wrData(wrData), .rdData(rdData), .rdAck(rdAck), .cmdUnmapped(cmdUnmapped),
    .clearFaults(clearFaults), .clearStatusBit(clearStatusBit), .outputOnCmd(outputOnCmd),
    .otherFaultOff(otherFaultOff), .outputEnable(outputEnable),
    .overTempStatus(overTempStatus), .latchedOff(latchedOff));
  otf_host_model u_host (.clk(clk), .rdAck(rdAck), .rdData(rdData), .cmdUnmapped(cmdUnmapped),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .cmdCode(cmdCode), .wrData(wrData));
  // ------
  // tasks
  // ------
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task rng(input string nm, input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask
  task waitFor(input bit latch, input logic v);
    n = 0;
    while ((latch ? latchedOff : outputEnable) !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask
  // clear by clear-faults, status bit clear, or output off then on
  task pulse(input int m);
    @(negedge clk);
    clearFaults = (m == 0);
    clearStatusBit = (m == 1);
    outputOnCmd = (m != 2);
    @(negedge clk);
    clearFaults = 1'h0;
    clearStatusBit = 1'h0;
    outputOnCmd = 1'h1;
    repeat (3) @(negedge clk);
  endtask
  task fault(input logic [7:0] act);
    u_host.wr(8'h50, {8'h00, act});
    temperature = hotTemp;
  endtask
  task test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done;
  end
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'h1;
    repeat (2) @(negedge clk);
    u_host.rd(8'h4F, d, u);
    chk("thrReset", d, 16'h007D);
    u_host.rd(8'h50, d, u);
    chk("actReset", d, 16'h0080);
    u_host.wr(8'h33, 16'h1234);
    u_host.rd(8'h33, d, u);
    chk("unmData", d, 16'h0000);
    chk("unmFlag", u, 16'h0001);
    u_host.wr(8'h4F, hotTemp);
    u_host.rd(8'h4F, d, u);
    chk("thrWr", d, hotTemp);
    u_host.wr(8'h50, 16'hFF05);
    u_host.rd(8'h50, d, u);
    chk("actWr", d, 16'h0005);
    $display("test registers done");
    temperature = hotTemp - 16'h0001;
    repeat (4) @(negedge clk);
    chk("below", overTempStatus, 16'h0000);
    temperature = hotTemp;
    repeat (3) @(negedge clk);
    chk("status", overTempStatus, 16'h0001);
    chk("ignore", outputEnable, 16'h0001);
    temperature = coolTemp;
    pulse(1);
    chk("statusClr", overTempStatus, 16'h0000);
    $display("test ignore done");
    for (int m = 0; m < 3; m++) begin
      fault(8'hC0);
      repeat (2) @(negedge clk);
      chk("offNow", outputEnable, 16'h0000);
      repeat (40) @(negedge clk);
      chk("latched", latchedOff, 16'h0001);
      temperature = coolTemp;
      pulse(m);
      chk("cleared", outputEnable, 16'h0001);
    end
    $display("test latch done");
    for (int r = 0; r < 7; r++) begin
      fault({2'h2, 3'(r), 3'h0});
      waitFor(1, 1'h1);
      rng("retries", n, 4 * r, 7 * r + 4);
      temperature = coolTemp;
      pulse(0);
    end
    $display("test retries done");
    for (int c = 0; c < 8; c++) begin
      fault({2'h2, 3'h1, 3'(c)});
      waitFor(0, 1'h0);
      temperature = coolTemp;
      waitFor(0, 1'h1);
      rng("spacing", n, (4 << c) - 1, (4 << c) + 3);
      chk("sticky", overTempStatus, 16'h0001);
      pulse(0);
    end
    $display("test spacing done");
    fault(8'h42);
    waitFor(0, 1'h0);
    rng("contDelay", n, 16, 21);
    repeat (2) @(negedge clk);
    chk("contLatch", latchedOff, 16'h0001);
    temperature = coolTemp;
    pulse(0);
    fault(8'hB8);
    repeat (200) @(negedge clk);
    chk("forever", latchedOff, 16'h0000);
    otherFaultOff = 1'h1;
    repeat (3) @(negedge clk);
    chk("otherOff", latchedOff, 16'h0001);
    otherFaultOff = 1'h0;
    temperature = coolTemp;
    pulse(0);
    chk("back", outputEnable, 16'h0001);
    $display("test response done");
    test_done;
  end
endmodule
bind otf_fault_response otf_fault_response_assertions u_chk (.clk(clk), .rstn(rstn),
  .temperature(temperature), .unitCycles(unitCycles), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .cmdCode(cmdCode), .wrData(wrData), .rdData(rdData), .rdAck(rdAck),
  .cmdUnmapped(cmdUnmapped), .clearFaults(clearFaults), .clearStatusBit(clearStatusBit),
  .outputOnCmd(outputOnCmd), .otherFaultOff(otherFaultOff), .outputEnable(outputEnable),
  .overTempStatus(overTempStatus), .latchedOff(latchedOff));
